// >>> qdrmc_ctrl.sv
// Notes on behaviour
// - Write data queue holds 64 entries of 74 bits with pointers and fill level.
// - Write queues cross from fabric write clock into the controller clock.
// - All 72 data bits pass to the SRAM unchanged, no parity work.
// - Write instruction queue holds 4 entries of 32 bits: ID, length, address.
// - Instruction full flag rises when one more instruction fits.
// - Sequencer waits for an instruction, then fetches its lines, then advances.
// - Each data ID is compared to the instruction ID; mismatch flags an error.
// - Data queue full flag follows a 4-bit programmable threshold.
// - One SRAM address bus shared; reads and writes never collide.
// - Configuration bit 0 selects two-word or four-word bursts.
// - Four-word mode drives the upper write word on the same edge as the address.
// - Read data is expected on the second rising edge after the read address.
// - Two-word mode: write data first, address with second word on the next rising edge.
// - Sequencers run on the double-rate clock to place address and data.
// - The write address counter loads from instruction addresses; the read address counter is never loaded.
// - 72-bit words split into 36-bit halves for writes, joined back for reads.
// - Read data is sampled on synchronised echo-clock edges and driven straight to rd_data_o.
// - An asynchronous soft reset from the fabric resets the controller.
module qdrmc_ctrl
  import qdrmc_pkg::*;
#(
  parameter int DEPTH = qdrmc_pkg::WDQ_DEPTH
) (
  input  wire logic                                  clock_i,
  input  wire logic                                  sys_rst_i,
  input  wire logic                                  controller_soft_reset_i,
  input  wire logic                                  fabric_write_clock_i,
  input  wire logic [qdrmc_pkg::WDQ_WIDTH-1:0]       wr_data_i,
  input  wire logic                                  wr_data_we_i,
  input  wire logic [qdrmc_pkg::INSTR_WIDTH-1:0]     wr_instr_i,
  input  wire logic                                  wr_instr_we_i,
  output logic                                       write_data_queue_full_o,
  output logic                                       write_instruction_queue_full_o,
  output logic                                       coherency_error_out_o,
  output qdrmc_pkg::qdrmc_sram_t                     sram_o,
  input  wire logic [qdrmc_pkg::SRAM_WORD-1:0]       sram_q_i,
  input  wire logic                                  echo_clock_i,
  output logic [qdrmc_pkg::LINE_WIDTH-1:0]           rd_data_o,
  output logic                                       rd_data_valid_o,
  input  wire logic                                  psel_i,
  input  wire logic                                  penable_i,
  input  wire logic                                  pwrite_i,
  input  wire logic [7:0]                            paddr_i,
  input  wire logic [31:0]                           pwdata_i,
  output logic [31:0]                                prdata_o,
  output logic                                       pready_o,
  output logic                                       pslverr_o
);
  import qdrmc_pkg::*;

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 4 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two >= 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and reset
  logic [2:0] wclk_s_r;
  logic [2:0] ecq_s_r;
  logic [1:0] srst_s_r;
  logic [1:0] wde_s_r;
  logic [1:0] wie_s_r;
  logic [WDQ_WIDTH-1:0]   wd_s1_r, wd_s2_r;
  logic [INSTR_WIDTH-1:0] wi_s1_r, wi_s2_r;
  logic [SRAM_WORD-1:0]   q_s1_r, q_s2_r;
  logic rst;

  always_ff @(posedge clock_i) begin
    wclk_s_r <= {wclk_s_r[1:0], fabric_write_clock_i};
    ecq_s_r  <= {ecq_s_r[1:0], echo_clock_i};
    srst_s_r <= {srst_s_r[0], controller_soft_reset_i};
    wde_s_r  <= {wde_s_r[0], wr_data_we_i};
    wie_s_r  <= {wie_s_r[0], wr_instr_we_i};
    wd_s1_r  <= wr_data_i;
    wd_s2_r  <= wd_s1_r;
    wi_s1_r  <= wr_instr_i;
    wi_s2_r  <= wi_s1_r;
    q_s1_r   <= sram_q_i;
    q_s2_r   <= q_s1_r;
  end

  assign rst = sys_rst_i | srst_s_r[1];

  wire wclk_rise = wclk_s_r[1] & ~wclk_s_r[2];
  wire ecq_rise  = ecq_s_r[1] & ~ecq_s_r[2];
  wire ecq_fall  = ~ecq_s_r[1] & ecq_s_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  logic [31:0] cfg_r;
  logic        coh_err_r;
  logic [31:0] prdata_nxt;
  logic        hit_cfg, hit_st, apb_acc;
  logic [AW:0] wdq_cnt;

  assign apb_acc = psel_i & penable_i;
  assign hit_cfg = paddr_i == CFG_OFFSET;
  assign hit_st  = paddr_i == STATUS_OFFSET;
  assign prdata_nxt = hit_cfg ? cfg_r :
                      hit_st  ? (32'(wdq_cnt) << ST_WDQ_LVL_LSB) | 32'(coh_err_r) : 32'h0;

  wire burst4 = cfg_r[CFG_BURST_BIT];
  wire [THR_WIDTH-1:0] thr = cfg_r[CFG_THR_LSB +: THR_WIDTH];

  always_ff @(posedge clock_i) begin
    if (rst) begin
      cfg_r     <= CFG_RESET;
      prdata_o  <= 32'h0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~pready_o & ~penable_i ? 1'b1 : 1'b0;
      pslverr_o <= psel_i & ~penable_i & ~(hit_cfg | hit_st);
      prdata_o  <= prdata_nxt;
      if (apb_acc && pready_o && pwrite_i && hit_cfg) cfg_r <= pwdata_i & 32'h0000_00f1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write data queue and instruction queue
  logic [WDQ_WIDTH-1:0]   wdq_mem [DEPTH];
  logic [INSTR_WIDTH-1:0] wiq_mem [WIQ_DEPTH];
  logic [AW:0] wdq_wp_r, wdq_rp_r;
  logic [2:0]  wiq_wp_r, wiq_rp_r;
  logic [2:0]  wiq_cnt;
  logic        wdq_push, wiq_push, wdq_pop, wiq_pop;
  logic [AW:0] full_lvl;

  assign wdq_push = wclk_rise & wde_s_r[1];
  assign wiq_push = wclk_rise & wie_s_r[1];
  assign wdq_cnt  = wdq_wp_r - wdq_rp_r;
  assign wiq_cnt  = wiq_wp_r - wiq_rp_r;
  // Threshold 15 means truly full, lower values scale the level in sixteenths
  assign full_lvl = (thr == 4'hf) ? (AW+1)'(DEPTH) : (AW+1)'((DEPTH * (32'(thr) + 1)) / 16);

  always_ff @(posedge clock_i) begin
    if (wdq_push) wdq_mem[wdq_wp_r[AW-1:0]] <= wd_s2_r;
    if (wiq_push) wiq_mem[wiq_wp_r[1:0]]    <= wi_s2_r;
  end

  always_ff @(posedge clock_i) begin
    if (rst) begin
      wdq_wp_r <= '0;
      wdq_rp_r <= '0;
      wiq_wp_r <= '0;
      wiq_rp_r <= '0;
      write_data_queue_full_o        <= 1'b0;
      write_instruction_queue_full_o <= 1'b0;
    end else begin
      if (wdq_push && wdq_cnt != (AW+1)'(DEPTH)) wdq_wp_r <= wdq_wp_r + 1'b1;
      if (wdq_pop)  wdq_rp_r <= wdq_rp_r + 1'b1;
      if (wiq_push && wiq_cnt != 3'(WIQ_DEPTH)) wiq_wp_r <= wiq_wp_r + 1'b1;
      if (wiq_pop)  wiq_rp_r <= wiq_rp_r + 1'b1;
      write_data_queue_full_o        <= wdq_cnt >= full_lvl;
      write_instruction_queue_full_o <= wiq_cnt >= 3'(WIQ_DEPTH - 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write sequencer
  typedef enum logic [1:0] {W_IDLE, W_FETCH, W_HI, W_LO} qdrmc_wst_t;
  qdrmc_wst_t   wst_r;
  qdrmc_instr_t ins_r;
  logic [LEN_WIDTH-1:0]  wlen_r;
  logic [ADDR_WIDTH-1:0] waddr_r;
  logic [WDQ_WIDTH-1:0]  wline_r;
  logic [1:0]            wdbeat_r;
  qdrmc_instr_t          ins_head;
  logic                  rd_busy;

  assign ins_head = qdrmc_instr_t'(wiq_mem[wiq_rp_r[1:0]][INS_ID_LSB+ID_WIDTH-1:0]);
  assign wiq_pop  = (wst_r == W_IDLE) && wiq_cnt != 3'd0 && !rd_busy;
  assign wdq_pop  = (wst_r == W_FETCH) && wlen_r != '0 && wdq_cnt != '0;

  always_ff @(posedge clock_i) begin
    if (rst) begin
      wst_r     <= W_IDLE;
      ins_r     <= '0;
      wlen_r    <= '0;
      waddr_r   <= '0;
      wline_r   <= '0;
      wdbeat_r  <= '0;
      coh_err_r <= 1'b0;
      coherency_error_out_o <= 1'b0;
    end else begin
      coherency_error_out_o <= coh_err_r;
      if (apb_acc && pready_o && pwrite_i && hit_st && pwdata_i[ST_COH_BIT]) coh_err_r <= 1'b0;
      case (wst_r)
        W_IDLE: begin
          if (wiq_pop) begin
            ins_r   <= ins_head;
            wlen_r  <= ins_head.len;
            waddr_r <= ins_head.addr;
            wst_r   <= W_FETCH;
          end
        end
        W_FETCH: begin
          if (wlen_r == '0) begin
            wst_r <= W_IDLE;
          end else if (wdq_pop) begin
            wline_r <= wdq_mem[wdq_rp_r[AW-1:0]];
            if (wdq_mem[wdq_rp_r[AW-1:0]][WD_ID_LSB +: ID_WIDTH] != ins_r.id) coh_err_r <= 1'b1;
            wst_r <= W_HI;
          end
        end
        W_HI: wst_r <= W_LO;
        W_LO: begin
          wlen_r   <= wlen_r - 1'b1;
          waddr_r  <= waddr_r + (burst4 ? 18'h2 : 18'h1);
          wdbeat_r <= wdbeat_r + 1'b1;
          wst_r    <= W_FETCH;
        end
        default: wst_r <= W_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SRAM port, address mux and read capture
  logic [LEN_WIDTH-1:0]  rlen_r;
  logic [ADDR_WIDTH-1:0] raddr_r;
  logic [SRAM_WORD-1:0]  rhi_r;
  logic [1:0]            rwait_r;
  wire w_addr_slot = (wst_r == W_HI) & (burst4 ? ~wdbeat_r[0] : 1'b1);

  assign rd_busy = rwait_r != 2'd0;

  always_ff @(posedge clock_i) begin
    if (rst) begin
      sram_o          <= '{addr: '0, wr_n: 1'b1, rd_n: 1'b1, d: '0};
      rlen_r          <= '0;
      raddr_r         <= '0;
      rhi_r           <= '0;
      rwait_r         <= '0;
      rd_data_o       <= '0;
      rd_data_valid_o <= 1'b0;
    end else begin
      rd_data_valid_o <= 1'b0;
      sram_o.rd_n     <= 1'b1;
      sram_o.wr_n     <= 1'b1;
      // Upper half first, then lower half at double rate
      if (wst_r == W_HI) sram_o.d <= wline_r[LINE_WIDTH-1 -: SRAM_WORD];
      if (wst_r == W_LO) sram_o.d <= wline_r[SRAM_WORD-1:0];
      if (w_addr_slot && burst4) begin
        sram_o.addr <= waddr_r;
        sram_o.wr_n <= 1'b0;
      end else if (wst_r == W_LO && !burst4) begin
        sram_o.addr <= waddr_r;
        sram_o.wr_n <= 1'b0;
      end else if (rlen_r != '0 && wst_r == W_IDLE && !rd_busy) begin
        sram_o.addr <= raddr_r;
        sram_o.rd_n <= 1'b0;
        rlen_r      <= rlen_r - 1'b1;
        raddr_r     <= raddr_r + (burst4 ? 18'h2 : 18'h1);
        rwait_r     <= 2'd2;
      end
      if (rd_busy && ecq_rise) rhi_r <= q_s2_r;
      if (rd_busy && ecq_fall) begin
        rd_data_o       <= {rhi_r, q_s2_r};
        rd_data_valid_o <= 1'b1;
        rwait_r         <= rwait_r - 1'b1;
      end
    end
  end
endmodule : qdrmc_ctrl

// >>> qdrmc_pkg.sv
package qdrmc_pkg;
  localparam int WDQ_DEPTH       = 64;
  localparam int WDQ_WIDTH       = 74;
  localparam int WIQ_DEPTH       = 4;
  localparam int INSTR_WIDTH     = 32;
  localparam int LINE_WIDTH      = 72;
  localparam int SRAM_WORD       = 36;
  localparam int ADDR_WIDTH      = 18;
  localparam int ID_WIDTH        = 2;
  localparam int LEN_WIDTH       = 6;
  localparam int THR_WIDTH       = 4;
  // Instruction field positions
  localparam int INS_ADDR_LSB    = 0;
  localparam int INS_LEN_LSB     = 18;
  localparam int INS_ID_LSB      = 24;
  // Data word ID position
  localparam int WD_ID_LSB       = 72;
  // APB register map
  localparam logic [7:0] CFG_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int CFG_BURST_BIT   = 0;
  localparam int CFG_THR_LSB     = 4;
  localparam int ST_COH_BIT      = 0;
  localparam int ST_WDQ_LVL_LSB  = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_00f0;

  typedef struct packed {
    logic [ID_WIDTH-1:0]   id;
    logic [LEN_WIDTH-1:0]  len;
    logic [ADDR_WIDTH-1:0] addr;
  } qdrmc_instr_t;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic                  wr_n;
    logic                  rd_n;
    logic [SRAM_WORD-1:0]  d;
  } qdrmc_sram_t;

  typedef enum logic [1:0] {BURST2, BURST4} qdrmc_burst_t;
endpackage : qdrmc_pkg

// >>> qdrmc_ctrl_asserts.sv
module qdrmc_ctrl_asserts
  import qdrmc_pkg::*;
#(
  parameter int DEPTH = qdrmc_pkg::WDQ_DEPTH
) (
  input wire logic                  clock_i,
  input wire logic                  sys_rst_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic                  pwrite_i,
  input wire logic [7:0]            paddr_i,
  input wire logic [31:0]           pwdata_i,
  input wire logic [31:0]           prdata_o,
  input wire logic                  pready_o,
  input wire logic                  pslverr_o,
  input wire logic                  coherency_error_out_o,
  input wire qdrmc_pkg::qdrmc_sram_t sram_o
);
  import qdrmc_pkg::*;
  logic mapped;
  logic clr;
  assign mapped = (paddr_i == CFG_OFFSET) || (paddr_i == STATUS_OFFSET);
  assign clr    = psel_i && penable_i && pready_o && pwrite_i && (paddr_i == STATUS_OFFSET) && pwdata_i[0];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  chk_ready_wait: assert property (psel_i && !penable_i |=> pready_o)
    else $error("ready not after one wait cycle");
  chk_ready_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access phase");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  chk_err_unmapped: assert property (pready_o && !pwrite_i && !mapped |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped read not refused");
  chk_err_mapped: assert property (pready_o && mapped |-> !pslverr_o)
    else $error("mapped access refused");
  chk_no_collide: assert property (!(!sram_o.wr_n && !sram_o.rd_n))
    else $error("read and write strobes together");
  chk_coh_sticky: assert property (coherency_error_out_o && !clr && !$past(clr) |=> coherency_error_out_o)
    else $error("coherency error dropped");
  chk_reset_idle: assert property ($fell(sys_rst_i) |-> sram_o.wr_n && sram_o.rd_n && !coherency_error_out_o)
    else $error("outputs not idle after reset");
  ////////////////////////////////////////////////////////////////////////////////
  cov_refused: cover property (pslverr_o);
  cov_sram_wr: cover property (!sram_o.wr_n);
  cov_coh_err: cover property ($rose(coherency_error_out_o));
endmodule : qdrmc_ctrl_asserts

bind qdrmc_ctrl qdrmc_ctrl_asserts #(.DEPTH(DEPTH)) u_qdrmc_ctrl_asserts (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .coherency_error_out_o(coherency_error_out_o), .sram_o(sram_o)
);

// >>> qdrmc_fabric_model.sv
module qdrmc_fabric_model
  import qdrmc_pkg::*;
(
  input  wire logic                         clock_i,
  input  wire logic                         instr_full_i,
  output logic                              fclk_o,
  output logic [qdrmc_pkg::WDQ_WIDTH-1:0]   wd_o,
  output logic                              wd_we_o,
  output logic [qdrmc_pkg::INSTR_WIDTH-1:0] wi_o,
  output logic                              wi_we_o,
  output logic [qdrmc_pkg::SRAM_WORD-1:0]   sram_q_o,
  output logic [6:0]                        lines_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import qdrmc_pkg::*;
  initial begin
    {fclk_o, wd_we_o, wi_we_o, lines_o, wd_o, wi_o, sram_q_o} = '0;
  end
  always @(posedge clock_i) sram_q_o <= ~sram_q_o;
  ////////////////////////////////////////////////////////////////////////////////
  // One burst, at most 63 lines, instruction with the last word
  task automatic send(input logic [5:0] n, input logic [1:0] id, input logic [1:0] did, input logic [17:0] a);
    int w;
    w = 0;
    while (instr_full_i !== 1'b0 && w < 1000) begin
      @(posedge clock_i);
      w++;
    end
    lines_o <= '0;
    for (int k = 0; k < n; k++) begin
      @(posedge clock_i);
      wd_o    <= {did, 36'($urandom), 36'($urandom)};
      wd_we_o <= 1'b1;
      wi_we_o <= (k == n - 1);
      wi_o    <= {6'h00, id, n, a};
      repeat (4) @(posedge clock_i);
      fclk_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      fclk_o  <= 1'b0;
      lines_o <= lines_o + 7'h01;
    end
    @(posedge clock_i);
    wd_we_o <= 1'b0;
    wi_we_o <= 1'b0;
    wd_o    <= ~wd_o;
    wi_o    <= ~wi_o;
  endtask : send
endmodule : qdrmc_fabric_model

// >>> testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import qdrmc_pkg::*;
  logic clk, rst, psel, pen, pwr, pready, perr, fclk, dwe, iwe, dfull, ifull, coh;
  logic [7:0]  padr;
  logic [31:0] pwd, prd, wi, v;
  logic [73:0] wd;
  logic [35:0] q;
  logic [6:0]  lines;
  qdrmc_sram_t sram;
  logic [32:0] eq[$];
  logic [31:0] mq[$];
  int          miscompares, cmp_count;

  qdrmc_ctrl u_qdrmc_ctrl (.clock_i(clk), .sys_rst_i(rst), .controller_soft_reset_i(1'b0),
    .fabric_write_clock_i(fclk), .wr_data_i(wd), .wr_data_we_i(dwe), .wr_instr_i(wi), .wr_instr_we_i(iwe),
    .write_data_queue_full_o(dfull), .write_instruction_queue_full_o(ifull), .coherency_error_out_o(coh),
    .sram_o(sram), .sram_q_i(q), .echo_clock_i(1'b0), .rd_data_o(), .rd_data_valid_o(), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready),
    .pslverr_o(perr));
  qdrmc_fabric_model u_qdrmc_fabric_model (.clock_i(clk), .instr_full_i(ifull), .fclk_o(fclk), .wd_o(wd),
    .wd_we_o(dwe), .wi_o(wi), .wi_we_o(iwe), .sram_q_o(q), .lines_o(lines));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_sim;
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e, input logic [31:0] m);
    int k;
    psel <= 1'b1; pwr <= w; padr <= a; pwd <= d;
    if (!w) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin miscompares++; end_sim(); end
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wait_flag(ref logic s, input logic e);
    int w;
    w = 0;
    while (s !== e && w < 2000) begin @(posedge clk); w++; end
    if (w >= 2000) begin miscompares++; end_sim(); end
  endtask : wait_flag
  task automatic wait_lines(input logic [6:0] n);
    int w;
    w = 0;
    while (lines !== n && w < 2000) begin @(posedge clk); w++; end
    if (w >= 2000) begin miscompares++; end_sim(); end
  endtask : wait_lines
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr) begin
      if (eq.size() == 0) miscompares++;
      else chk("apb_read", eq.pop_front(), {perr, prd & mq.pop_front()});
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  initial begin
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; padr = 8'h00; pwd = 32'h0;
    v = $urandom(1);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, CFG_OFFSET, 32'h0, {1'b0, CFG_RESET}, 32'hffff_ffff);
    apb(1'b0, STATUS_OFFSET, 32'h0, 33'h0, 32'h1);
    apb(1'b0, 8'h08, 32'h0, {1'b1, 32'h0}, 32'hffff_ffff);
    v = $urandom;
    apb(1'b1, CFG_OFFSET, v, 33'h0, 32'h0);
    apb(1'b0, CFG_OFFSET, 32'h0, {1'b0, v & 32'h0000_00f1}, 32'hffff_ffff);
    // Threshold 0: full from 64/16 = 4 lines, no instruction yet
    apb(1'b1, CFG_OFFSET, 32'h0, 33'h0, 32'h0);
    fork
      u_qdrmc_fabric_model.send(6'd8, 2'd1, 2'd1, 18'h00123);
      begin
        wait_lines(7'd5);
        chk("data_full", 33'h1, {32'h0, dfull});
      end
    join
    wait_flag(dfull, 1'b0);
    chk("data_full", 33'h0, {32'h0, dfull});
    apb(1'b1, CFG_OFFSET, CFG_RESET, 33'h0, 32'h0);
    u_qdrmc_fabric_model.send(6'd3, 2'd2, 2'd2, 18'h00200);
    fork
      u_qdrmc_fabric_model.send(6'd4, 2'd3, 2'd0, 18'h00300);
      begin
        wait_lines(7'd2);
        chk("coh_error", 33'h0, {32'h0, coh});
      end
    join
    wait_flag(coh, 1'b1);
    chk("coh_error", 33'h1, {32'h0, coh});
    repeat (30) @(posedge clk);
    apb(1'b0, STATUS_OFFSET, 32'h0, 33'h1, 32'h1);
    apb(1'b1, STATUS_OFFSET, 32'h1, 33'h0, 32'h0);
    apb(1'b0, STATUS_OFFSET, 32'h0, 33'h0, 32'h1);
    wait_flag(coh, 1'b0);
    apb(1'b1, CFG_OFFSET, 32'h0000_00f1, 33'h0, 32'h0);
    u_qdrmc_fabric_model.send(6'd2, 2'd1, 2'd1, 18'h00400);
    wait_flag(ifull, 1'b0);
    chk("instr_full", 33'h0, {32'h0, ifull});
    chk("coh_error", 33'h0, {32'h0, coh});
    end_sim();
  end
endmodule : testbench
